// *** acrpc_ctrl.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
`include "acrpc_regs.svh"

module acrpc_ctrl
  import acrpc_pkg::*;
#(
  parameter int NUM_INPUTS = 16 // Implemented analog inputs
) (
  input wire logic sys_clk_i, // System clock, 200 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wr_data_i, // Write data
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  output logic [7:0] rd_data_o, // Read data, cycle after strobe
  output logic irq_o, // Level interrupt
  output acrpc_core_s core_o, // Mux, reference and pin control
  output acrpc_result_t dac_code_o, // Trial code to the DAC
  input wire logic cmp_i, // Comparator pin
  input wire logic rc_clk_i // Dedicated RC clock pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  if (NUM_INPUTS != 12 && NUM_INPUTS != 16) begin : g_bad_inputs
    $error("NUM_INPUTS must be 12 or 16");
  end

  localparam logic [15:0] IMPL_MASK = (NUM_INPUTS == 16) ? 16'hffff : 16'h0fff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Analog pin map for a pin code
  function automatic logic [15:0] pin_map(input logic [3:0] code);
    logic [15:0] map;
    map = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      map[i] = (code == 4'h0) || (i < (15 - int'(code)));
    end
    return map;
  endfunction : pin_map

  // Acquisition length in bit periods
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'd0;
      3'h1: acq_tads = 5'd2;
      3'h2: acq_tads = 5'd4;
      3'h3: acq_tads = 5'd6;
      3'h4: acq_tads = 5'd8;
      3'h5: acq_tads = 5'd12;
      3'h6: acq_tads = 5'd16;
      default: acq_tads = 5'd20;
    endcase
  endfunction : acq_tads

  // Result bytes in the chosen justification
  function automatic logic [15:0] fmt_result(input acrpc_result_t r, input logic right);
    if (right) begin
      fmt_result = {6'h00, r};
    end else begin
      fmt_result = {r, 6'h00};
    end
  endfunction : fmt_result

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic conv_on_q;
  logic [3:0] input_select_q;
  logic [1:0] reference_select_q;
  logic [3:0] pin_analog_map_q;
  logic result_align_q;
  logic [2:0] acquisition_time_select_q;
  logic [2:0] conversion_clock_select_q;
  logic [7:0] result_high_byte_q;
  logic [7:0] result_low_byte_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  acrpc_state_e state_q;
  logic [4:0] cnt_q;
  logic tad_tick;
  logic sar_done;
  acrpc_result_t sar_code;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic wr_opctl;
  logic wr_refpin;
  logic wr_timfmt;
  logic wr_mask;
  logic rd_stat;

  always_comb begin
    wr_opctl = 1'b0;
    wr_refpin = 1'b0;
    wr_timfmt = 1'b0;
    wr_mask = 1'b0;
    rd_stat = rd_en_i && (addr_i == `ACRPC_OFF_IRQ_STAT);
    if (!wr_en_i) begin
      wr_opctl = 1'b0;
    end else if (addr_i == `ACRPC_OFF_OPCTL) begin
      wr_opctl = 1'b1;
    end else if (addr_i == `ACRPC_OFF_REFPIN) begin
      wr_refpin = 1'b1;
    end else if (addr_i == `ACRPC_OFF_TIMFMT) begin
      wr_timfmt = 1'b1;
    end else if (addr_i == `ACRPC_OFF_IRQ_MASK) begin
      wr_mask = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, refuse and abort requests

  logic go_wr;
  logic start_req;
  logic refuse_req;
  logic abort_req;
  logic busy;

  assign busy = (state_q == ACRPC_ST_ACQ) || (state_q == ACRPC_ST_CONV);
  assign go_wr = wr_opctl && wr_data_i[`ACRPC_OPCTL_GO];
  // Start needs the converter already on and kept on
  assign start_req = go_wr && conv_on_q && wr_data_i[`ACRPC_OPCTL_ON] &&
                     (state_q == ACRPC_ST_IDLE);
  assign refuse_req = go_wr && !busy && !start_req;
  // Clearing the busy flag or the enable drops a running conversion
  assign abort_req = busy && wr_opctl &&
                     (!wr_data_i[`ACRPC_OPCTL_GO] || !wr_data_i[`ACRPC_OPCTL_ON]);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_on_q <= 1'b0;
      input_select_q <= 4'h0;
    end else if (wr_opctl) begin
      conv_on_q <= wr_data_i[`ACRPC_OPCTL_ON];
      input_select_q <= wr_data_i[`ACRPC_OPCTL_CHS_LSB +: 4];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_select_q <= 2'h0;
      pin_analog_map_q <= 4'h0;
    end else if (wr_refpin) begin
      reference_select_q <= wr_data_i[`ACRPC_REFPIN_VCFG_LSB +: 2];
      pin_analog_map_q <= wr_data_i[`ACRPC_REFPIN_PCFG_LSB +: 4];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_align_q <= 1'b0;
      acquisition_time_select_q <= 3'h0;
      conversion_clock_select_q <= 3'h0;
    end else if (wr_timfmt) begin
      result_align_q <= wr_data_i[`ACRPC_TIMFMT_ALIGN];
      acquisition_time_select_q <= wr_data_i[`ACRPC_TIMFMT_ACQT_LSB +: 3];
      conversion_clock_select_q <= wr_data_i[`ACRPC_TIMFMT_ADCS_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ACRPC_ST_IDLE;
      cnt_q <= 5'd0;
    end else begin
      case (state_q)
        ACRPC_ST_IDLE: begin
          if (start_req && acq_tads(acquisition_time_select_q) == 5'd0) begin
            state_q <= ACRPC_ST_CONV;
          end else if (start_req) begin
            state_q <= ACRPC_ST_ACQ;
            cnt_q <= acq_tads(acquisition_time_select_q);
          end
        end
        ACRPC_ST_ACQ: begin
          if (abort_req || !conv_on_q) begin
            state_q <= ACRPC_ST_IDLE;
          end else if (tad_tick && cnt_q == 5'd1) begin
            state_q <= ACRPC_ST_CONV;
          end else if (tad_tick) begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        ACRPC_ST_CONV: begin
          if (abort_req || !conv_on_q) begin
            state_q <= ACRPC_ST_IDLE;
          end else if (sar_done) begin
            state_q <= ACRPC_ST_GAP;
            cnt_q <= `ACRPC_GAP_TADS;
          end
        end
        ACRPC_ST_GAP: begin
          if (!conv_on_q || (tad_tick && cnt_q == 5'd1)) begin
            state_q <= ACRPC_ST_IDLE;
          end else if (tad_tick) begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        default: begin
          state_q <= ACRPC_ST_IDLE;
        end
      endcase
    end
  end

  logic sar_start;
  logic sar_abort;

  assign sar_start = (state_q == ACRPC_ST_IDLE && start_req &&
                      acq_tads(acquisition_time_select_q) == 5'd0) ||
                     (state_q == ACRPC_ST_ACQ && !abort_req && conv_on_q &&
                      tad_tick && cnt_q == 5'd1);
  assign sar_abort = (state_q == ACRPC_ST_CONV) && (abort_req || !conv_on_q);

  ////////////////////////////////////////////////////////////////////////////
  // Result pair

  logic [15:0] result_fmt;

  assign result_fmt = fmt_result(sar_code, result_align_q);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_high_byte_q <= `ACRPC_RESULT_RST;
      result_low_byte_q <= `ACRPC_RESULT_RST;
    end else if (state_q == ACRPC_ST_CONV && sar_done) begin
      result_high_byte_q <= result_fmt[15:8];
      result_low_byte_q <= result_fmt[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (rd_stat) begin
      irq_stat_d = 2'h0;
    end
    // Set wins over the read clear
    if (state_q == ACRPC_ST_CONV && sar_done && conv_on_q) begin
      irq_stat_d[`ACRPC_IRQ_DONE] = 1'b1;
    end
    if (refuse_req) begin
      irq_stat_d[`ACRPC_IRQ_REFUSED] = 1'b1;
    end
    irq_mask_d = wr_mask ? wr_data_i[1:0] : irq_mask_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= `ACRPC_IRQ_RST;
      irq_mask_q <= `ACRPC_IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_o <= |(irq_stat_d & irq_mask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (!rd_en_i) begin
      rd_data_o <= 8'h00;
    end else if (addr_i == `ACRPC_OFF_RES_HI) begin
      rd_data_o <= result_high_byte_q;
    end else if (addr_i == `ACRPC_OFF_RES_LO) begin
      rd_data_o <= result_low_byte_q;
    end else if (addr_i == `ACRPC_OFF_OPCTL) begin
      rd_data_o <= {2'h0, input_select_q, busy && conv_on_q, conv_on_q};
    end else if (addr_i == `ACRPC_OFF_REFPIN) begin
      rd_data_o <= {2'h0, reference_select_q, pin_analog_map_q};
    end else if (addr_i == `ACRPC_OFF_TIMFMT) begin
      rd_data_o <= {result_align_q, 1'b0, acquisition_time_select_q,
                    conversion_clock_select_q};
    end else if (addr_i == `ACRPC_OFF_IRQ_STAT) begin
      rd_data_o <= {6'h00, irq_stat_q};
    end else if (addr_i == `ACRPC_OFF_IRQ_MASK) begin
      rd_data_o <= {6'h00, irq_mask_q};
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog side drive

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_o <= '0;
    end else begin
      core_o.converter_on <= conv_on_q;
      // Hold capacitor disconnected while converting and while the converter is off
      core_o.sample_enable <= conv_on_q && (state_q != ACRPC_ST_CONV);
      core_o.input_select <= input_select_q;
      core_o.channel_valid <= IMPL_MASK[input_select_q];
      core_o.reference_select <= reference_select_q;
      core_o.pin_analog_map <= pin_map(pin_analog_map_q) & IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit period clock and approximation engine

  acrpc_tad_gen u_tad_gen (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state_q != ACRPC_ST_IDLE && !(state_q == ACRPC_ST_CONV && sar_done)),
    .clk_sel_i(conversion_clock_select_q),
    .rc_clk_i(rc_clk_i),
    .tick_o(tad_tick)
  );

  acrpc_sar u_sar (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .step_i(tad_tick && state_q == ACRPC_ST_CONV),
    .cmp_i(cmp_i),
    .dac_code_o(sar_code),
    .done_o(sar_done)
  );

  assign dac_code_o = sar_code;

endmodule : acrpc_ctrl

// *** acrpc_regs.svh ***
`ifndef ACRPC_REGS_SVH
`define ACRPC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define ACRPC_OFF_RES_HI 4'h0
`define ACRPC_OFF_RES_LO 4'h1
`define ACRPC_OFF_OPCTL 4'h2
`define ACRPC_OFF_REFPIN 4'h3
`define ACRPC_OFF_TIMFMT 4'h4
`define ACRPC_OFF_IRQ_STAT 4'h5
`define ACRPC_OFF_IRQ_MASK 4'h6

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ACRPC_OPCTL_ON 0
`define ACRPC_OPCTL_GO 1
`define ACRPC_OPCTL_CHS_LSB 2
`define ACRPC_REFPIN_PCFG_LSB 0
`define ACRPC_REFPIN_VCFG_LSB 4
`define ACRPC_TIMFMT_ADCS_LSB 0
`define ACRPC_TIMFMT_ACQT_LSB 3
`define ACRPC_TIMFMT_ALIGN 7
`define ACRPC_IRQ_DONE 0
`define ACRPC_IRQ_REFUSED 1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ACRPC_OPCTL_RST 8'h00
`define ACRPC_REFPIN_RST 8'h00
`define ACRPC_TIMFMT_RST 8'h00
`define ACRPC_IRQ_RST 2'h0
`define ACRPC_RESULT_RST 8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing counts, in conversion bit periods
`define ACRPC_GAP_TADS 5'd2
`define ACRPC_RESULT_BITS 10

`endif

// *** acrpc_pkg.sv ***
package acrpc_pkg;

  typedef enum logic [3:0] {
    ACRPC_ST_IDLE = 4'b0001,
    ACRPC_ST_ACQ = 4'b0010,
    ACRPC_ST_CONV = 4'b0100,
    ACRPC_ST_GAP = 4'b1000
  } acrpc_state_e;

  typedef logic [9:0] acrpc_result_t;

  // Drive toward the analog multiplexer and sample-and-hold
  typedef struct packed {
    logic converter_on;
    logic sample_enable;
    logic [3:0] input_select;
    logic channel_valid;
    logic [1:0] reference_select;
    logic [15:0] pin_analog_map;
  } acrpc_core_s;

endpackage : acrpc_pkg

// *** acrpc_tad_gen.sv ***
`timescale 1ns/10ps
module acrpc_tad_gen (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic run_i, // Count while high
  input wire logic [2:0] clk_sel_i, // Conversion clock select
  input wire logic rc_clk_i, // Dedicated RC clock pin
  output logic tick_o // One pulse per bit period
);

  logic [5:0] div_q;
  logic [2:0] rc_sync_q;
  logic rc_level_q;

  // Divide ratio minus one; zero selects the RC clock
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0: div_last = 6'h01;
      3'h1: div_last = 6'h07;
      3'h2: div_last = 6'h1f;
      3'h4: div_last = 6'h03;
      3'h5: div_last = 6'h0f;
      3'h6: div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  endfunction : div_last

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_sync_q <= 3'h0;
      rc_level_q <= 1'b0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], rc_clk_i};
      if (rc_sync_q[1] == rc_sync_q[2]) begin
        rc_level_q <= rc_sync_q[2];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 6'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      div_q <= 6'h00;
      tick_o <= 1'b0;
    end else if (div_last(clk_sel_i) == 6'h00) begin
      div_q <= 6'h00;
      tick_o <= rc_sync_q[1] && rc_sync_q[2] && !rc_level_q;
    end else if (div_q == div_last(clk_sel_i)) begin
      div_q <= 6'h00;
      tick_o <= 1'b1;
    end else begin
      div_q <= div_q + 6'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : acrpc_tad_gen

// *** acrpc_sar.sv ***
`timescale 1ns/10ps
module acrpc_sar
  import acrpc_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic start_i, // Begin a conversion
  input wire logic abort_i, // Drop the conversion
  input wire logic step_i, // One bit period elapsed
  input wire logic cmp_i, // Comparator pin, input at or above trial code
  output acrpc_result_t dac_code_o, // Trial code to the DAC
  output logic done_o // One pulse when the result is final
);

  logic [2:0] cmp_sync_q;
  logic cmp_level_q;
  logic [3:0] bit_q;
  logic busy_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_sync_q <= 3'h0;
      cmp_level_q <= 1'b0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[1:0], cmp_i};
      if (cmp_sync_q[1] == cmp_sync_q[2]) begin
        cmp_level_q <= cmp_sync_q[2];
      end
    end
  end

  // One bit decided per bit period, MSB first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_code_o <= 10'h000;
      bit_q <= 4'h0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_q <= 1'b0;
      end else if (start_i) begin
        dac_code_o <= 10'h200;
        bit_q <= 4'h9;
        busy_q <= 1'b1;
      end else if (busy_q && step_i) begin
        dac_code_o[bit_q] <= cmp_level_q;
        if (bit_q == 4'h0) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
        end else begin
          dac_code_o[bit_q - 4'h1] <= 1'b1;
          bit_q <= bit_q - 4'h1;
        end
      end
    end
  end

endmodule : acrpc_sar

// *** acrpc_analog_model.sv ***
`timescale 1ns/10ps
module acrpc_analog_model
  import acrpc_pkg::*;
(
  input wire acrpc_core_s core_i, // Mux control
  input wire acrpc_result_t dac_code_i, // Trial code
  output logic cmp_o, // Comparator
  output logic rc_clk_o // RC clock
);
  acrpc_result_t level [16];
  acrpc_result_t held;
  logic routed;
  initial begin
    rc_clk_o = 1'b0;
    held = '0;
    foreach (level[i]) level[i] = '0;
  end
  always #100 rc_clk_o = ~rc_clk_o;
  // Track while sampling, hold after
  always @* begin
    if (core_i.sample_enable) held = level[core_i.input_select];
  end
  assign routed = core_i.converter_on && core_i.channel_valid
    && core_i.pin_analog_map[core_i.input_select];
  // Unrouted comparator wanders
  assign cmp_o = routed ? (dac_code_i <= held) : rc_clk_o;
endmodule : acrpc_analog_model

// *** acrpc_ctrl_assertions.sv ***
`timescale 1ns/10ps
module acrpc_ctrl_assertions
  import acrpc_pkg::*;
#(
  parameter int NUM_INPUTS = 16 // Implemented inputs
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [3:0] addr_i, // Address
  input wire logic [7:0] wr_data_i, // Write data
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  input wire logic [7:0] rd_data_o, // Read data
  input wire logic irq_o, // Interrupt
  input wire acrpc_core_s core_o, // Core control
  input wire acrpc_result_t dac_code_o, // Trial code
  input wire logic cmp_i, // Comparator
  input wire logic rc_clk_i // RC clock
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  function automatic logic [15:0] pin_map(input logic [3:0] k);
    logic [15:0] m;
    m = (k == 4'h0) ? 16'hffff : (16'h0001 << (4'hf - k)) - 16'h0001;
    if (NUM_INPUTS == 12) m[15:12] = 4'h0;
    return m;
  endfunction : pin_map

  ////////////////////////////////////////////////////////////////////////////
  a_rd_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside read");
  a_rd_top_zero: assert property ($past(rd_en_i) && $past(addr_i) inside {4'h2, 4'h3}
    |-> rd_data_o[7:6] == 2'b00) else $error("control upper bits not zero");
  a_rd_unmapped: assert property ($past(rd_en_i) && $past(addr_i) > 4'h6
    |-> rd_data_o == 8'h00) else $error("unmapped read not zero");
  a_sel_follow: assert property (wr_en_i && addr_i == 4'h2
    |-> ##2 core_o.input_select == $past(wr_data_i[5:2], 2))
    else $error("input select not applied");
  a_on_follow: assert property (wr_en_i && addr_i == 4'h2
    |-> ##2 core_o.converter_on == $past(wr_data_i[0], 2))
    else $error("enable not applied");
  a_ref_follow: assert property (wr_en_i && addr_i == 4'h3
    |-> ##2 core_o.reference_select == $past(wr_data_i[5:4], 2))
    else $error("reference select not applied");
  a_pin_decode: assert property (wr_en_i && addr_i == 4'h3
    |-> ##2 core_o.pin_analog_map == pin_map($past(wr_data_i[3:0], 2)))
    else $error("pin map decode wrong");
  a_chan_valid: assert property ($past(rst_n_i) |->
    core_o.channel_valid == (core_o.input_select < NUM_INPUTS))
    else $error("channel valid wrong");
  a_sample_off: assert property (core_o.sample_enable |-> core_o.converter_on)
    else $error("sampling while disabled");
  a_mask_quiet: assert property (wr_en_i && addr_i == 4'h6 && wr_data_i == 8'h00
    |-> ##2 !irq_o[*3]) else $error("interrupt with mask clear");
endmodule : acrpc_ctrl_assertions

bind acrpc_ctrl acrpc_ctrl_assertions #(.NUM_INPUTS(NUM_INPUTS)) u_acrpc_ctrl_assertions (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
  .core_o(core_o), .dac_code_o(dac_code_o), .cmp_i(cmp_i), .rc_clk_i(rc_clk_i));

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import acrpc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [7:0] rd_data_o;
  logic irq_o;
  acrpc_core_s core_o;
  acrpc_result_t dac_code_o;
  logic cmp_i;
  logic rc_clk_i;
  int n_fail = 0;
  int total_checks = 0;
  int acq_t [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int div_t [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  always #2.5 sys_clk_i = ~sys_clk_i;

  acrpc_ctrl u_acrpc_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .irq_o(irq_o), .core_o(core_o), .dac_code_o(dac_code_o), .cmp_i(cmp_i),
    .rc_clk_i(rc_clk_i));
  acrpc_analog_model u_acrpc_analog_model (.core_i(core_o), .dac_code_i(dac_code_o),
    .cmp_o(cmp_i), .rc_clk_o(rc_clk_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rd_data_o;
  endtask : rd

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    for (int a = 0; a < 7; a++) begin
      rd_chk("reset value", a[3:0], 8'h00);
    end
    chk("reset pin map", core_o.pin_analog_map, 16'hffff);
    chk("reset core", {core_o.converter_on, core_o.input_select}, 16'h0000);
    chk("reset channel", {14'h0, core_o.channel_valid, core_o.sample_enable}, 16'h0002);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_regs;
    logic [15:0] m;
    wr(4'h2, 8'hf5);
    rd_chk("operation control", 4'h2, 8'h35);
    chk("core select", {core_o.converter_on, core_o.input_select}, 16'h001d);
    for (int k = 0; k < 16; k++) begin
      wr(4'h3, {2'b11, k[1:0], k[3:0]});
      rd_chk("ref pin config", 4'h3, {2'b00, k[1:0], k[3:0]});
      m = (k == 0) ? 16'hffff : (16'h0001 << (15 - k)) - 16'h0001;
      chk("pin map", core_o.pin_analog_map, m);
      chk("reference", {14'h0, core_o.reference_select}, {14'h0, k[1:0]});
    end
    wr(4'h3, 8'h00);
    wr(4'h4, 8'hff);
    rd_chk("timing format", 4'h4, 8'hbf);
    wr(4'h0, 8'hff);
    rd_chk("result read only", 4'h0, 8'h00);
    wr(4'h9, 8'hff);
    rd_chk("unmapped", 4'h9, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_convert(input logic [7:0] tim, input acrpc_result_t lvl,
                              input logic [3:0] ch);
    int n;
    int t;
    logic [7:0] hi;
    logic [7:0] lo;
    u_acrpc_analog_model.level[ch] = lvl;
    wr(4'h6, 8'h01);
    wr(4'h4, tim);
    wr(4'h2, {2'b00, ch, 2'b01});
    wr(4'h2, {2'b00, ch, 2'b11});
    rd_chk("busy set", 4'h2, {2'b00, ch, 2'b11});
    n = 0;
    while (irq_o !== 1'b1 && n < 4000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("conversion done", {15'h0, irq_o}, 16'h0001);
    t = (acq_t[tim[5:3]] + 10) * div_t[tim[2:0]] - 1;
    if (div_t[tim[2:0]] > 0) begin
      chk("conversion time", {15'h0, n >= t - 4 && n <= t + 6}, 16'h0001);
    end
    rd_chk("busy clear", 4'h2, {2'b00, ch, 2'b01});
    rd(4'h0, hi);
    rd(4'h1, lo);
    chk("result pair", {hi, lo}, tim[7] ? {6'h00, lvl} : {lvl, 6'h00});
    chk("final code", {6'h00, dac_code_o}, {6'h00, lvl});
    rd_chk("done status", 4'h5, 8'h01);
    @(negedge sys_clk_i);
    chk("irq cleared", {15'h0, irq_o}, 16'h0000);
    repeat (200) @(posedge sys_clk_i);
    $display("test_convert done");
  endtask : test_convert

  task automatic test_refuse_abort;
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h02);
    wr(4'h2, 8'h02);
    repeat (2) @(negedge sys_clk_i);
    chk("refused irq", {15'h0, irq_o}, 16'h0001);
    rd_chk("busy while off", 4'h2, 8'h00);
    rd_chk("refused status", 4'h5, 8'h02);
    wr(4'h6, 8'h01);
    wr(4'h2, 8'h02);
    repeat (2) @(negedge sys_clk_i);
    chk("masked irq", {15'h0, irq_o}, 16'h0000);
    rd_chk("masked status", 4'h5, 8'h02);
    wr(4'h4, 8'h02);
    wr(4'h2, 8'h01);
    wr(4'h2, 8'h03);
    repeat (20) @(posedge sys_clk_i);
    wr(4'h2, 8'h01);
    rd_chk("busy aborted", 4'h2, 8'h01);
    repeat (600) @(posedge sys_clk_i);
    rd_chk("abort status", 4'h5, 8'h00);
    chk("abort irq", {15'h0, irq_o}, 16'h0000);
    wr(4'h6, 8'h00);
    wr(4'h2, 8'h02);
    repeat (4) @(negedge sys_clk_i);
    chk("quiet irq", {15'h0, irq_o}, 16'h0000);
    rd_chk("quiet status", 4'h5, 8'h02);
    $display("test_refuse_abort done");
  endtask : test_refuse_abort

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    test_reset();
    test_regs();
    test_convert(8'h8a, 10'h2c7, 4'h5);
    test_convert(8'h3d, 10'h135, 4'hb);
    test_convert(8'h86, 10'h3ff, 4'h0);
    test_convert(8'h03, 10'h001, 4'h9);
    test_refuse_abort();
    finish_test();
  end
endmodule : tb_top
